// >>> shared/avtc_pkg.sv
// Constants shared by the auxiliary voltage and temperature channel block
package avtc_pkg;

   // ----------------------------------------------------------------
   // Register addresses
   // ----------------------------------------------------------------
   localparam logic [15:0] ADDR_STATUS_FLAGS_ZERO = 16'he502;
   localparam logic [15:0] ADDR_IRQ_ENABLE_ZERO = 16'he50a;
   localparam logic [15:0] ADDR_MAIN_SETUP = 16'he618;
   localparam logic [15:0] ADDR_SETUP_THREE = 16'he708;
   localparam logic [15:0] ADDR_TEMP_OFFSET_BASE = 16'he800;
   localparam logic [15:0] ADDR_THERMAL_SCALE_BASE = 16'he810;
   localparam logic [15:0] ADDR_THERMAL_RESULT_BASE = 16'he820;
   localparam logic [15:0] ADDR_VOLT_SCALE_BASE = 16'he830;
   localparam logic [15:0] ADDR_VOLT_SAMPLE_BASE = 16'he840;

   // ----------------------------------------------------------------
   // Field positions and reset values
   // ----------------------------------------------------------------
   localparam int SAMPLE_READY_BIT = 17;
   localparam int HIGHPASS_ENABLE_BIT = 4;
   localparam logic [1:0] PIN_FUNC_READY = 2'b00;
   localparam logic [15:0] MAIN_SETUP_RST = 16'h0010;
   localparam logic [7:0] SETUP_THREE_RST = 8'h0f;
   localparam logic [31:0] IRQ_ENABLE_RST = 32'h0000_0000;

   // ----------------------------------------------------------------
   // Datapath constants
   // ----------------------------------------------------------------
   localparam int TEMP_OFFSET_SHIFT = 11;
   localparam int GAIN_FRAC_BITS = 23;
   localparam int HPF_SHIFT = 8;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_KHZ = 25_000;
   localparam int CLK_PERIOD_NS = 40;
   localparam int PIN_DELAY_NS = 70;
   localparam int PIN_LOW_NS = 10_000;
   localparam int TEMP_SETTLE_MS = 1024;
   localparam int PIN_DELAY_CYC = (PIN_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PIN_LOW_CYC = PIN_LOW_NS / CLK_PERIOD_NS;
   localparam int TEMP_SETTLE_CYC = TEMP_SETTLE_MS * CLK_KHZ;

   // ----------------------------------------------------------------
   // Ready pulse sequencer states
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      PIN_IDLE = 2'b00,
      PIN_WAIT = 2'b01,
      PIN_LOW = 2'b10
   } avtc_pin_state_t;

endpackage

// >>> src/avtc_channel.sv
// Second voltage, temperature and phase voltage channel processing
`timescale 1ns/100ps

// Operation
// R01 - Select bit one drives select line high
// R02 - Select bit zero drives line low, temperature
// R03 - Hold per-phase signed offset from link
// R04 - Shift stored offset left eleven bits
// R05 - Scale temperature by one plus gain fraction
// R06 - Results after 1.024 s, then each sample
// R07 - Host keeps select low 1.024 s
// R08 - Host converts result to degrees Celsius
// R09 - Temperature result read zero-padded to 32
// R10 - Scale voltages by one plus gain fraction
// R11 - Voltage gain feeds every downstream use
// R12 - Voltage gain read sign-extended, four zeros
// R13 - Setup bit 4 enables all highpass filters
// R14 - Capture eight filtered voltages per sample
// R15 - Ready flag sets, masked interrupt raised
// R16 - Pin low after 70 ns for 10 us
// R17 - Host may burst-read on pin rising edge
// R18 - Voltage samples read sign-extended to 32
// R19 - Compensation active once temperature valid
module avtc_channel
   import avtc_pkg::*;
#(
   parameter int SETTLE_CYC = TEMP_SETTLE_CYC
)
(
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic resetn_i,
   // Register access port
   input wire logic [15:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_rd_i,
   output logic [31:0] reg_rdata_o,
   output logic reg_rvalid_o,
   // Front-end sample stream, one frame per 8 kSPS sample
   input wire logic adc_valid_i,
   input wire logic [3:0][23:0] adc_primary_i,
   input wire logic [3:0][23:0] adc_second_i,
   output logic adc_ready_o,
   // Temperature offsets decoded from the bit stream link
   input wire logic [3:0] offset_valid_i,
   input wire logic [3:0][7:0] offset_data_i,
   // Filtered phase voltages towards the power engine
   output logic volt_valid_o,
   output logic [3:0][23:0] volt_data_o,
   input wire logic volt_ready_i,
   // Pins and status
   output logic [3:0] sense_select_line_o,
   output logic shared_ready_pulse_pin_n_o,
   output logic irq_n_o,
   output logic [3:0] shunt_comp_active_o
);

   // ----------------------------------------------------------------
   // State record
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [15:0] main_setup;
      logic [7:0] setup_three;
      logic [31:0] irq_enable;
      logic ready_flag;
      logic [3:0][7:0] temp_offset;
      logic [3:0][23:0] thermal_scale;
      logic [3:0][23:0] thermal_result;
      logic [7:0][23:0] volt_scale;
      logic [7:0][23:0] volt_sample;
      logic [7:0][23:0] dc_est;
      logic [3:0][24:0] settle_cnt;
      logic [3:0] temp_ok;
      logic [3:0] sel;
      avtc_pin_state_t pin_state;
      logic [8:0] pin_cnt;
      logic pin_n;
      logic irq_n;
      logic [31:0] rdata;
      logic rvalid;
      logic in_ready;
      logic head_v;
      logic tail_v;
      logic [3:0][23:0] head;
      logic [3:0][23:0] tail;
   } avtc_state_t;

   avtc_state_t s_q;
   avtc_state_t s_d;

   localparam logic [24:0] SETTLE_LAST = 25'(SETTLE_CYC - 1);
   localparam logic [1:0] PIN_WAIT_LOAD = 2'(PIN_DELAY_CYC - 1);
   localparam logic [8:0] PIN_LOW_LOAD = 9'(PIN_LOW_CYC - 1);

   // ----------------------------------------------------------------
   // Arithmetic helpers
   // ----------------------------------------------------------------

   // Clamp to 24 bits; wrap-around would flip the sign of a loud sample
   function automatic logic [23:0] avtc_sat(input logic signed [25:0] v);
      logic [23:0] r;
      r = v[23:0];
      if (v > 26'sh7f_ffff)
      begin
         r = 24'h7f_ffff;
      end
      else if (v < -26'sh80_0000)
      begin
         r = 24'h80_0000;
      end
      return r;
   endfunction

   // Multiply by one plus gain over two to the 23rd
   function automatic logic [23:0] avtc_scale(input logic signed [23:0] x, input logic signed [23:0] g);
      logic signed [47:0] p;
      logic signed [25:0] sum;
      p = x * g;
      sum = 26'(x) + 26'(p >>> GAIN_FRAC_BITS);
      return avtc_sat(sum);
   endfunction

   // ----------------------------------------------------------------
   // Per-phase datapath
   // ----------------------------------------------------------------
   logic [7:0][23:0] scaled;
   logic [7:0][23:0] hpf_out;
   logic [7:0][23:0] dc_next;
   logic [3:0][23:0] temp_next;

   genvar gp;
   genvar gk;
   generate
      for (gp = 0; gp < 4; gp++)
      begin : g_phase
         logic signed [25:0] temp_sum;
         // Primary and second voltage, gain ahead of the filter
         assign scaled[2*gp] = avtc_scale(adc_primary_i[gp], s_q.volt_scale[2*gp]); // R10
         assign scaled[2*gp+1] = avtc_scale(adc_second_i[gp], s_q.volt_scale[2*gp+1]); // R10
         for (gk = 0; gk < 2; gk++)
         begin : g_hpf
            logic signed [25:0] diff;
            assign diff = 26'($signed(scaled[2*gp+gk])) - 26'($signed(s_q.dc_est[2*gp+gk]));
            // Bypass passes the scaled sample and freezes the estimate
            assign hpf_out[2*gp+gk] = s_q.main_setup[HIGHPASS_ENABLE_BIT] ? avtc_sat(diff) :
                                      scaled[2*gp+gk]; // R13
            assign dc_next[2*gp+gk] = avtc_sat(26'($signed(s_q.dc_est[2*gp+gk])) + (diff >>> HPF_SHIFT));
         end
         // Offset is placed eleven bits up before the sum
         assign temp_sum = 26'($signed(adc_second_i[gp])) +
                           $signed({{7{s_q.temp_offset[gp][7]}}, s_q.temp_offset[gp],
                                    {TEMP_OFFSET_SHIFT{1'b0}}}); // R04
         assign temp_next[gp] = avtc_scale(avtc_sat(temp_sum), s_q.thermal_scale[gp]); // R05
      end
   endgenerate

   // ----------------------------------------------------------------
   // Register read word
   // ----------------------------------------------------------------
   logic [31:0] rd_word;
   always_comb
   begin
      rd_word = 32'h0000_0000;
      if (reg_addr_i == ADDR_STATUS_FLAGS_ZERO)
      begin
         rd_word[SAMPLE_READY_BIT] = s_q.ready_flag;
      end
      else if (reg_addr_i == ADDR_IRQ_ENABLE_ZERO)
      begin
         rd_word = s_q.irq_enable;
      end
      else if (reg_addr_i == ADDR_MAIN_SETUP)
      begin
         rd_word = {16'h0000, s_q.main_setup};
      end
      else if (reg_addr_i == ADDR_SETUP_THREE)
      begin
         rd_word = {24'h00_0000, s_q.setup_three};
      end
      else if (reg_addr_i[15:2] == ADDR_TEMP_OFFSET_BASE[15:2])
      begin
         rd_word = {{24{s_q.temp_offset[reg_addr_i[1:0]][7]}}, s_q.temp_offset[reg_addr_i[1:0]]};
      end
      else if (reg_addr_i[15:2] == ADDR_THERMAL_SCALE_BASE[15:2])
      begin
         rd_word = {{4{s_q.thermal_scale[reg_addr_i[1:0]][23]}}, s_q.thermal_scale[reg_addr_i[1:0]], 4'h0};
      end
      else if (reg_addr_i[15:2] == ADDR_THERMAL_RESULT_BASE[15:2])
      begin
         rd_word = {8'h00, s_q.thermal_result[reg_addr_i[1:0]]}; // R09
      end
      else if (reg_addr_i[15:3] == ADDR_VOLT_SCALE_BASE[15:3])
      begin
         rd_word = {{4{s_q.volt_scale[reg_addr_i[2:0]][23]}}, s_q.volt_scale[reg_addr_i[2:0]], 4'h0}; // R12
      end
      else if (reg_addr_i[15:3] == ADDR_VOLT_SAMPLE_BASE[15:3])
      begin
         rd_word = {{8{s_q.volt_sample[reg_addr_i[2:0]][23]}}, s_q.volt_sample[reg_addr_i[2:0]]}; // R18
      end
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   logic take;
   logic pop;
   always_comb
   begin
      s_d = s_q;
      // A frame is taken only while the buffer has room: stall, never drop
      take = adc_valid_i & s_q.in_ready;
      pop = volt_ready_i & s_q.head_v;

      // Register writes
      if (reg_wr_i)
      begin
         if (reg_addr_i == ADDR_STATUS_FLAGS_ZERO && reg_wdata_i[SAMPLE_READY_BIT])
         begin
            s_d.ready_flag = 1'b0;
         end
         if (reg_addr_i == ADDR_IRQ_ENABLE_ZERO)
         begin
            s_d.irq_enable = reg_wdata_i;
         end
         if (reg_addr_i == ADDR_MAIN_SETUP)
         begin
            s_d.main_setup = reg_wdata_i[15:0]; // R13
         end
         if (reg_addr_i == ADDR_SETUP_THREE)
         begin
            s_d.setup_three = reg_wdata_i[7:0];
         end
         if (reg_addr_i[15:2] == ADDR_THERMAL_SCALE_BASE[15:2])
         begin
            s_d.thermal_scale[reg_addr_i[1:0]] = reg_wdata_i[27:4];
         end
         if (reg_addr_i[15:3] == ADDR_VOLT_SCALE_BASE[15:3])
         begin
            s_d.volt_scale[reg_addr_i[2:0]] = reg_wdata_i[27:4];
         end
      end

      // Read answer one cycle after the strobe
      s_d.rvalid = reg_rd_i;
      s_d.rdata = reg_rd_i ? rd_word : 32'h0000_0000;

      // Per-phase select lines, offsets and settle timers
      for (int p = 0; p < 4; p++)
      begin
         s_d.sel[p] = s_q.setup_three[p]; // R01 R02
         if (offset_valid_i[p])
         begin
            s_d.temp_offset[p] = offset_data_i[p]; // R03
         end
         // Timer restarts whenever the line goes back high
         if (s_q.sel[p])
         begin
            s_d.settle_cnt[p] = 25'd0;
            s_d.temp_ok[p] = 1'b0;
         end
         else if (s_q.settle_cnt[p] == SETTLE_LAST)
         begin
            s_d.temp_ok[p] = 1'b1; // R06 R19
         end
         else
         begin
            s_d.settle_cnt[p] = s_q.settle_cnt[p] + 25'd1;
         end
      end

      // Sample capture at the frame rate
      if (take)
      begin
         s_d.ready_flag = 1'b1; // R15
         for (int c = 0; c < 8; c++)
         begin
            s_d.volt_sample[c] = hpf_out[c]; // R14 R11
            if (s_q.main_setup[HIGHPASS_ENABLE_BIT])
            begin
               s_d.dc_est[c] = dc_next[c];
            end
         end
         for (int p = 0; p < 4; p++)
         begin
            if (!s_q.sel[p] && s_q.temp_ok[p])
            begin
               s_d.thermal_result[p] = temp_next[p]; // R06
            end
         end
      end

      // Two-entry buffer towards the power engine
      if (pop)
      begin
         s_d.head_v = s_q.tail_v;
         s_d.head = s_q.tail;
         s_d.tail_v = 1'b0;
      end
      if (take)
      begin
         if (!s_d.head_v)
         begin
            s_d.head_v = 1'b1;
            s_d.head = {hpf_out[6], hpf_out[4], hpf_out[2], hpf_out[0]}; // R11
         end
         else
         begin
            s_d.tail_v = 1'b1;
            s_d.tail = {hpf_out[6], hpf_out[4], hpf_out[2], hpf_out[0]}; // R11
         end
      end
      s_d.in_ready = !s_d.tail_v;

      // Ready pulse; a new frame during a pulse does not restart it
      case (s_q.pin_state)
         PIN_IDLE:
         begin
            if (take && s_q.main_setup[1:0] == PIN_FUNC_READY)
            begin
               s_d.pin_state = PIN_WAIT; // R16
               s_d.pin_cnt = 9'(PIN_WAIT_LOAD);
            end
         end
         PIN_WAIT:
         begin
            if (s_q.pin_cnt == 9'd0)
            begin
               s_d.pin_state = PIN_LOW; // R16
               s_d.pin_cnt = PIN_LOW_LOAD;
            end
            else
            begin
               s_d.pin_cnt = s_q.pin_cnt - 9'd1;
            end
         end
         PIN_LOW:
         begin
            if (s_q.pin_cnt == 9'd0)
            begin
               s_d.pin_state = PIN_IDLE;
            end
            else
            begin
               s_d.pin_cnt = s_q.pin_cnt - 9'd1;
            end
         end
         default:
         begin
            s_d.pin_state = PIN_IDLE;
         end
      endcase
      s_d.pin_n = (s_d.pin_state != PIN_LOW); // R16

      // Interrupt follows the flag gated by its enable
      s_d.irq_n = !(s_d.ready_flag & s_d.irq_enable[SAMPLE_READY_BIT]); // R15
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         s_q <= '0;
         s_q.main_setup <= MAIN_SETUP_RST;
         s_q.setup_three <= SETUP_THREE_RST;
         s_q.irq_enable <= IRQ_ENABLE_RST;
         s_q.sel <= 4'hf;
         s_q.pin_state <= PIN_IDLE;
         s_q.pin_n <= 1'b1;
         s_q.irq_n <= 1'b1;
         s_q.in_ready <= 1'b1;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs, all straight from the state register
   // ----------------------------------------------------------------
   assign reg_rdata_o = s_q.rdata;
   assign reg_rvalid_o = s_q.rvalid;
   assign adc_ready_o = s_q.in_ready;
   assign volt_valid_o = s_q.head_v;
   assign volt_data_o = s_q.head;
   assign sense_select_line_o = s_q.sel;
   assign shared_ready_pulse_pin_n_o = s_q.pin_n;
   assign irq_n_o = s_q.irq_n;
   assign shunt_comp_active_o = s_q.temp_ok;

endmodule // avtc_channel

// >>> tb/avtc_channel_chk.sv
// Concurrent checks on the channel block ports
`timescale 1ns/100ps
module avtc_channel_chk
   import avtc_pkg::*;
#(
   parameter int SETTLE_CYC = 20
)
(
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic resetn_i,
   // Register port
   input wire logic [15:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_rd_i,
   input wire logic reg_rvalid_o,
   // Streams
   input wire logic adc_valid_i,
   input wire logic adc_ready_o,
   input wire logic volt_valid_o,
   input wire logic [3:0][23:0] volt_data_o,
   input wire logic volt_ready_i,
   // Pins
   input wire logic [3:0] sense_select_line_o,
   input wire logic shared_ready_pulse_pin_n_o,
   input wire logic irq_n_o,
   input wire logic [3:0] shunt_comp_active_o
);
   logic [8:0] low_q;
   logic [31:0] sel_q;
   logic take;
   assign take = adc_valid_i && adc_ready_o;
   // Counts of pin low time and phase A select low time
   always_ff @(posedge core_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         low_q <= '0;
         sel_q <= '0;
      end
      else
      begin
         low_q <= shared_ready_pulse_pin_n_o ? 9'h000 : low_q + 9'h001;
         sel_q <= sense_select_line_o[0] ? 32'h0000_0000 : sel_q + 32'h0000_0001;
      end
   end
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!resetn_i);
   // Pins, counters, streams and register reads
   a_reset_lines: assert property ($rose(resetn_i) |-> sense_select_line_o == 4'hf) else $error("lines not high");
   a_select_follow: assert property (reg_wr_i && reg_addr_i == ADDR_SETUP_THREE |->
      ##2 sense_select_line_o == $past(reg_wdata_i[3:0], 2)) else $error("select lines wrong");
   a_pin_len: assert property ($rose(shared_ready_pulse_pin_n_o) |-> low_q == PIN_LOW_CYC)
      else $error("pin low time wrong");
   a_pin_delay: assert property ($fell(shared_ready_pulse_pin_n_o) |-> $past(take, 3) || $past(take, 4))
      else $error("pin fell at wrong time");
   a_irq_delay: assert property ($fell(irq_n_o) |-> $past(take) ||
      $past(reg_wr_i && reg_addr_i == ADDR_IRQ_ENABLE_ZERO)) else $error("irq fell at wrong time");
   a_take_push: assert property (take |=> volt_valid_o) else $error("frame lost");
   a_stall_hold: assert property (volt_valid_o && !volt_ready_i |=> volt_valid_o && $stable(volt_data_o))
      else $error("stalled word changed");
   a_full_only: assert property (!adc_ready_o |-> volt_valid_o) else $error("refused while empty");
   a_read_answer: assert property (reg_rd_i |=> reg_rvalid_o) else $error("read not answered");
   a_comp_off: assert property ((shunt_comp_active_o & sense_select_line_o & $past(sense_select_line_o, 2)) == 4'h0)
      else $error("compensation while line high");
   a_comp_settle: assert property ($rose(shunt_comp_active_o[0]) |-> sel_q >= SETTLE_CYC - 1 &&
      sel_q <= SETTLE_CYC + 3) else $error("settle time wrong");
endmodule // avtc_channel_chk

bind avtc_channel avtc_channel_chk #(.SETTLE_CYC(SETTLE_CYC)) u_chk (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
   .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i),
   .reg_rvalid_o(reg_rvalid_o), .adc_valid_i(adc_valid_i), .adc_ready_o(adc_ready_o), .volt_valid_o(volt_valid_o),
   .volt_data_o(volt_data_o), .volt_ready_i(volt_ready_i), .sense_select_line_o(sense_select_line_o),
   .shared_ready_pulse_pin_n_o(shared_ready_pulse_pin_n_o), .irq_n_o(irq_n_o),
   .shunt_comp_active_o(shunt_comp_active_o));

// >>> tb/avtc_frontend_model.sv
// Behavioural model of the front-ends feeding the sample stream
`timescale 1ns/100ps
module avtc_frontend_model
(
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic resetn_i,
   // Frame request
   input wire logic send_i,
   input wire logic [3:0][23:0] prim_i,
   input wire logic [3:0][23:0] sec_i,
   // Sample stream
   output logic adc_valid_o,
   output logic [3:0][23:0] adc_primary_o,
   output logic [3:0][23:0] adc_second_o,
   input wire logic adc_ready_i
);
   // Hold frame until taken, then invert lines so stale data never passes
   always_ff @(posedge core_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         adc_valid_o <= 1'b0;
         adc_primary_o <= '0;
         adc_second_o <= '0;
      end
      else if (send_i)
      begin
         adc_valid_o <= 1'b1;
         adc_primary_o <= prim_i;
         adc_second_o <= sec_i;
      end
      else if (adc_valid_o && adc_ready_i)
      begin
         adc_valid_o <= 1'b0;
         adc_primary_o <= ~adc_primary_o;
         adc_second_o <= ~adc_second_o;
      end
   end
endmodule // avtc_frontend_model

// >>> tb/avtc_channel_tb_top.sv
// Self-checking testbench for the channel block
`timescale 1ns/100ps
module avtc_channel_tb_top;
   import avtc_pkg::*;
   localparam int SIM_SETTLE = 20;
   logic clk, rst_n, wr_en, rd_en, rvalid, adc_valid, adc_ready, v_valid, v_ready, pin_n, irq_n, send;
   logic [15:0] addr;
   logic [31:0] wdata, rdata, rd_val;
   logic [3:0][23:0] adc_p, adc_s, v_data, prim, sec;
   logic [3:0] ofs_valid, sel, comp;
   logic [3:0][7:0] ofs_data;
   int fail_count;
   int check_count;
   // Block, front-end model
   avtc_channel #(.SETTLE_CYC(SIM_SETTLE)) u_dut (.core_clk_i(clk), .resetn_i(rst_n), .reg_addr_i(addr),
      .reg_wr_i(wr_en), .reg_wdata_i(wdata), .reg_rd_i(rd_en), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
      .adc_valid_i(adc_valid), .adc_primary_i(adc_p), .adc_second_i(adc_s), .adc_ready_o(adc_ready),
      .offset_valid_i(ofs_valid), .offset_data_i(ofs_data), .volt_valid_o(v_valid), .volt_data_o(v_data),
      .volt_ready_i(v_ready), .sense_select_line_o(sel), .shared_ready_pulse_pin_n_o(pin_n), .irq_n_o(irq_n),
      .shunt_comp_active_o(comp));
   avtc_frontend_model u_fe (.core_clk_i(clk), .resetn_i(rst_n), .send_i(send), .prim_i(prim), .sec_i(sec),
      .adc_valid_o(adc_valid), .adc_primary_o(adc_p), .adc_second_o(adc_s), .adc_ready_i(adc_ready));
   // Shared helpers
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask
   task automatic rdc(input logic [15:0] a, input logic [31:0] exp);
      @(posedge clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      #1;
      rd_val = rvalid ? rdata : 32'hdead_beef;
      check(rd_val, exp);
   endtask
   // Frame waits for the take unless the buffer test wants it held
   task automatic frame(input logic [23:0] pa, input logic [23:0] pb, input logic [23:0] sa, input bit wt);
      int n;
      @(posedge clk);
      prim <= {48'h0, pb, pa};
      sec <= {72'h0, sa};
      send <= 1'b1;
      @(posedge clk);
      send <= 1'b0;
      // Let the model's valid settle before polling it
      #1;
      for (n = 0; wt && n < 50 && adc_valid !== 1'b0; n++)
         @(posedge clk) #1;
      check({31'h0, n < 50}, 32'h0000_0001);
   endtask
   task automatic pin_high();
      int n;
      for (n = 0; n < 300 && pin_n !== 1'b1; n++)
         @(posedge clk);
      check({31'h0, pin_n}, 32'h0000_0001);
   endtask
   // Scenarios
   task automatic t_reset();
      check({26'h0, sel, pin_n, irq_n}, 32'h0000_003f);
      rdc(ADDR_MAIN_SETUP, {16'h0, MAIN_SETUP_RST});
      rdc(ADDR_SETUP_THREE, {24'h0, SETUP_THREE_RST});
      rdc(ADDR_IRQ_ENABLE_ZERO, IRQ_ENABLE_RST);
      rdc(16'h1234, 32'h0000_0000);
      wr(ADDR_VOLT_SAMPLE_BASE, 32'h0000_0055);
      rdc(ADDR_VOLT_SAMPLE_BASE, 32'h0000_0000);
      wr(ADDR_VOLT_SCALE_BASE, 32'h0800_0000);
      rdc(ADDR_VOLT_SCALE_BASE, 32'hf800_0000);
   endtask
   task automatic t_datapath();
      wr(ADDR_MAIN_SETUP, 32'h0000_0000);
      wr(ADDR_VOLT_SCALE_BASE, 32'h0400_0000);
      wr(ADDR_IRQ_ENABLE_ZERO, 32'h0002_0000);
      frame(24'h00_0100, 24'hff_ff00, 24'h00_0000, 1'b1);
      check({7'h0, irq_n, v_data[0]}, 32'h0000_0180);
      repeat (5) @(posedge clk);
      check({31'h0, pin_n}, 32'h0000_0000);
      pin_high();
      rdc(ADDR_VOLT_SAMPLE_BASE, 32'h0000_0180);
      rdc(ADDR_VOLT_SAMPLE_BASE + 16'h0002, 32'hffff_ff00);
      rdc(ADDR_STATUS_FLAGS_ZERO, 32'h0002_0000);
      wr(ADDR_STATUS_FLAGS_ZERO, 32'h0002_0000);
      rdc(ADDR_STATUS_FLAGS_ZERO, 32'h0000_0000);
      check({31'h0, irq_n}, 32'h0000_0001);
      wr(ADDR_IRQ_ENABLE_ZERO, 32'h0000_0000);
      wr(ADDR_MAIN_SETUP, 32'h0000_0001);
      frame(24'h00_0010, 24'h00_0020, 24'h00_0000, 1'b1);
      repeat (6) @(posedge clk);
      check({30'h0, pin_n, irq_n}, 32'h0000_0003);
   endtask
   task automatic t_highpass();
      wr(ADDR_MAIN_SETUP, 32'h0000_0010);
      frame(24'h00_0000, 24'h00_1000, 24'h00_0000, 1'b1);
      rdc(ADDR_VOLT_SAMPLE_BASE + 16'h0002, 32'h0000_1000);
      frame(24'h00_0000, 24'h00_1000, 24'h00_0000, 1'b1);
      rdc(ADDR_VOLT_SAMPLE_BASE + 16'h0002, 32'h0000_0ff0);
      pin_high();
   endtask
   task automatic t_buffer();
      wr(ADDR_MAIN_SETUP, 32'h0000_0001);
      v_ready <= 1'b0;
      for (int i = 1; i < 4; i++)
         frame(24'h00_0000, 24'(i), 24'h00_0000, i < 3);
      repeat (3) @(posedge clk) #1;
      check({30'h0, adc_ready, adc_valid}, 32'h0000_0001);
      for (int i = 1; i < 4; i++)
      begin
         repeat (3) @(posedge clk) #1;
         check({7'h0, v_valid, v_data[1]}, {8'h01, 24'(i)});
         @(posedge clk) v_ready <= 1'b1;
         @(posedge clk) v_ready <= 1'b0;
      end
      repeat (3) @(posedge clk) #1;
      check({31'h0, v_valid}, 32'h0000_0000);
      v_ready <= 1'b1;
   endtask
   task automatic t_temp();
      @(posedge clk);
      ofs_data[0] <= 8'hfe;
      ofs_valid[0] <= 1'b1;
      @(posedge clk);
      ofs_valid <= 4'h0;
      ofs_data[0] <= 8'h01;
      rdc(ADDR_TEMP_OFFSET_BASE, 32'hffff_fffe);
      wr(ADDR_THERMAL_SCALE_BASE, 32'h0400_0000);
      wr(ADDR_SETUP_THREE, 32'h0000_000e);
      repeat (2) @(posedge clk) #1;
      check({28'h0, sel}, 32'h0000_000e);
      frame(24'h00_0000, 24'h00_0000, 24'hff_f000, 1'b1);
      rdc(ADDR_THERMAL_RESULT_BASE, 32'h0000_0000);
      repeat (SIM_SETTLE + 5) @(posedge clk) #1;
      check({28'h0, comp}, 32'h0000_0001);
      frame(24'h00_0000, 24'h00_0000, 24'hff_f000, 1'b1);
      rdc(ADDR_THERMAL_RESULT_BASE, 32'h00ff_d000);
      wr(ADDR_SETUP_THREE, 32'h0000_000f);
      repeat (4) @(posedge clk) #1;
      check({24'h0, sel, comp}, 32'h0000_00f0);
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Clock, watchdog, main sequence
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   initial
   begin
      #400_000;
      fail_count++;
      $display("BAD %0t watchdog expired", $time);
      close_out();
   end
   initial
   begin
      {rst_n, wr_en, rd_en, send, addr, wdata, ofs_valid, ofs_data} = '0;
      {prim, sec} = '0;
      v_ready = 1'b1;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_datapath();
      t_highpass();
      t_buffer();
      t_temp();
      close_out();
   end
endmodule // avtc_channel_tb_top
